// [logic/fault_flag_defs.svh]
// Purpose: Constants shared by the fault flag command logic
// Assumes: 32-bit serial frames, 200 MHz system clock
// Notes: reset values and bit positions of the returned words
// Notes on behaviour
// - Fault read address 0x21, flags low
// - Event flag sets on change, clears on read
// - Bit 10 latches frame errors until read
// - Bit 9 latches check mismatch until gone and read
// - Bit 7 undervoltage, clears when gone and read
// - Bit 6 overvoltage, clears when gone and read
// - Bit 5 thermal warning, clears gone and read
// - Bit 4 thermal limit, clears gone and read
// - Bit 3 interrupt line wake, read clears
// - Bit 2 wake pin falling edge, read clears
// - Bit 1 serial wake, read clears
// - Bit 0 power-on reset, clears when gone and read
// - Interrupt request gives 100 us low pulse
// - Interrupt request echo carries summary bits only
// - Interrupt request echo frame does not clear event flag
// - Soft reset write gives a one-cycle soft_reset_pulse
// - Soft reset answer uses switch status layout
// - Frame: address, read/write bit, 24 data
// - Summary fault holds until read and clear
// - Returned event flag clears; no re-raise
// - Chip select fall starts 32-clock transfer
// - Summary and event flag set after reset
`ifndef FAULT_FLAG_DEFS_SVH
`define FAULT_FLAG_DEFS_SVH

`define ADDR_FAULT 7'h21
`define ADDR_INT_REQ 7'h23
`define ADDR_SOFT_RST 7'h24
`define ADDR_SW_STATUS 7'h1f
`define ADDR_MAX 7'h24
`define ECHO_SW_STATUS 8'h3e
`define FRAME_BITS 6'h20
`define FLAG_MASK 22'h00_06ff
`define FLAGS_RST 22'h00_0001
`define FAULT_SUM_RST 1'b1
`define INTFLG_RST 1'b1
`define PIN_RST 34'h0_0000_001a
`define INT_PULSE_US 100
`define CLK_PERIOD_PS 5000
`define INT_PULSE_CYCLES ((`INT_PULSE_US * 1000 * 1000) / `CLK_PERIOD_PS)

`endif

// [logic/fault_flag_pkg.sv]
// Purpose: Types for the fault flag command logic
// Assumes: Nothing beyond the constants header
// Notes: Response kinds select the word loaded for the next frame
package fault_flag_pkg;
	typedef logic [31:0] frame_t;
	typedef enum logic [1:0] {
		RESP_ECHO,
		RESP_FAULT,
		RESP_SWITCH,
		RESP_INT_REQ
	} resp_kind_e;
endpackage

// [logic/spi_link_if.sv]
// Purpose: Carries one serial frame between shifter and command logic
// Assumes: All members are on clk_sys
// Notes: Strobes are one-cycle pulses
`timescale 1ns/1ps
interface spi_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	fault_flag_pkg::frame_t tx_word;
	fault_flag_pkg::frame_t rx_word;
	logic frame_start;
	logic frame_done;
	logic frame_bad;
	modport engine (input sclk, cs_n, mosi, tx_word,
		output miso, rx_word, frame_start, frame_done, frame_bad);
	modport ctrl (output sclk, cs_n, mosi, tx_word,
		input miso, rx_word, frame_start, frame_done, frame_bad);
endinterface

// [logic/spi_frame_engine.sv]
// Purpose: Shifts a 32-bit frame in and the answer word out
// Assumes: Pins already synchronised, clock idles low, sample on rise
// Notes: Answer word is loaded at the chip select fall
`timescale 1ns/1ps
`include "fault_flag_defs.svh"
module spi_frame_engine (
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	// Frame link
	spi_link_if.engine lnk
);
	logic sclk_q_ff;
	logic cs_q_ff;
	logic [5:0] cnt_ff;
	logic [31:0] out_ff;
	logic [31:0] rx_ff;

	wire sclk_rise = lnk.sclk & ~sclk_q_ff;
	wire sclk_fall = ~lnk.sclk & sclk_q_ff;
	wire cs_fall = cs_q_ff & ~lnk.cs_n;
	wire cs_rise = ~cs_q_ff & lnk.cs_n;
	wire active = ~lnk.cs_n & ~cs_fall;
	// Counter saturates so a long frame still reads as malformed
	wire [5:0] nxt_cnt = (cnt_ff == 6'h3f) ? cnt_ff : cnt_ff + 6'h01;

	assign lnk.frame_start = cs_fall;
	assign lnk.frame_done = cs_rise;
	assign lnk.frame_bad = cs_rise & (cnt_ff != `FRAME_BITS);
	assign lnk.miso = out_ff[31];
	assign lnk.rx_word = rx_ff;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sclk_q_ff <= 1'b0;
			cs_q_ff <= 1'b1;
		end else begin
			sclk_q_ff <= lnk.sclk;
			cs_q_ff <= lnk.cs_n;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_ff <= 6'h00;
			rx_ff <= 32'h0000_0000;
		end else if (cs_fall) begin
			cnt_ff <= 6'h00;
		end else if (active && sclk_rise) begin
			cnt_ff <= nxt_cnt;
			rx_ff <= {rx_ff[30:0], lnk.mosi};
		end
	end

	// Shifting waits for the first rise so bit 31 stands a full clock
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			out_ff <= 32'h0000_0000;
		end else if (cs_fall) begin
			out_ff <= lnk.tx_word;
		end else if (active && sclk_fall && cnt_ff != 6'h00) begin
			out_ff <= {out_ff[30:0], 1'b0};
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	load_word_a: assert property (cs_fall |=> out_ff == $past(lnk.tx_word))
		else $error("answer word not loaded at frame start");
endmodule

// [logic/fault_flag_command_block.sv]
// Purpose: Serial command logic for fault flags, interrupt pulse, soft reset
// Assumes: All pins asynchronous to clk_sys; sclk far slower than clk_sys
// Notes: The answer to a command leaves in the following frame
`timescale 1ns/1ps
`include "fault_flag_defs.svh"
module fault_flag_command_block #(
	parameter int INT_PULSE_CYCLES = `INT_PULSE_CYCLES
) (
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial port
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// Interrupt line, open drain
	input wire logic int_n_in,
	output logic int_n_out,
	output logic int_n_oe,
	// Wake pin
	input wire logic wake_n,
	// Switch and monitor inputs
	input wire logic [13:0] ground_switch_inputs,
	input wire logic [7:0] programmable_switch_inputs,
	input wire logic low_supply_cmp,
	input wire logic high_supply_cmp,
	input wire logic thermal_warning_cmp,
	input wire logic thermal_limit_cmp,
	input wire logic battery_supply_low,
	input wire logic hash_mismatch,
	input wire logic sleep_state,
	// Status and control outputs
	output logic soft_reset_pulse,
	output logic fault_summary,
	output logic event_flag,
	output logic [21:0] fault_flags
);
	localparam int NPIN = 34;
	localparam int CW = $clog2(INT_PULSE_CYCLES + 1);

	logic [NPIN-1:0] sync1_ff;
	logic [NPIN-1:0] sync2_ff;
	logic [NPIN-1:0] sync3_ff;
	logic [NPIN-1:0] pin_ff;
	logic int_prev_ff;
	logic wake_prev_ff;
	logic [21:0] sw_prev_ff;
	logic [21:0] flags_ff;
	logic fault_sum_ff;
	logic intflg_ff;
	logic [7:0] echo_ff;
	fault_flag_pkg::resp_kind_e resp_ff;
	logic soft_rst_ff;
	logic pulse_on_ff;
	logic [CW-1:0] pulse_cnt_ff;

	wire sleep_s;
	wire hash_s;
	wire por_s;
	wire tl_s;
	wire tw_s;
	wire ov_s;
	wire uv_s;
	wire [21:0] sw_s;
	wire wake_s;
	wire int_s;
	wire mosi_s;
	wire cs_s;
	wire sclk_s;

	spi_link_if lnk();

	spi_frame_engine u_engine (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.lnk(lnk.engine)
	);

	// A pin moves only once the second and third stages agree
	wire [NPIN-1:0] pin_raw = {sleep_state, hash_mismatch,
		battery_supply_low, thermal_limit_cmp, thermal_warning_cmp,
		high_supply_cmp, low_supply_cmp, programmable_switch_inputs,
		ground_switch_inputs, wake_n, int_n_in, mosi, cs_n, sclk};
	wire [NPIN-1:0] pin_diff = sync2_ff ^ sync3_ff;
	wire [NPIN-1:0] nxt_pin = (sync2_ff & ~pin_diff) | (pin_ff & pin_diff);

	assign {sleep_s, hash_s, por_s, tl_s, tw_s, ov_s, uv_s, sw_s,
		wake_s, int_s, mosi_s, cs_s, sclk_s} = pin_ff;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_ff <= `PIN_RST;
			sync2_ff <= `PIN_RST;
			sync3_ff <= `PIN_RST;
			pin_ff <= `PIN_RST;
		end else begin
			sync1_ff <= pin_raw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			pin_ff <= nxt_pin;
		end
	end

	assign lnk.sclk = sclk_s;
	assign lnk.cs_n = cs_s;
	assign lnk.mosi = mosi_s;
	assign miso = lnk.miso;
	assign miso_oe = ~cs_s;

	// Command decode, shared by the answer selection and the actions
	function automatic fault_flag_pkg::resp_kind_e kind_of(
		input fault_flag_pkg::frame_t w
	);
		logic zero;
		zero = (w[23:0] == 24'h00_0000);
		if (w[31:25] == `ADDR_FAULT && !w[24])
			kind_of = fault_flag_pkg::RESP_FAULT;
		else if (w[31:25] == `ADDR_INT_REQ && w[24] && zero)
			kind_of = fault_flag_pkg::RESP_INT_REQ;
		else if (w[31:25] == `ADDR_SOFT_RST && w[24] && zero)
			kind_of = fault_flag_pkg::RESP_SWITCH;
		else if (w[31:25] == `ADDR_SW_STATUS && !w[24])
			kind_of = fault_flag_pkg::RESP_SWITCH;
		else
			kind_of = fault_flag_pkg::RESP_ECHO;
	endfunction

	wire frame_good = lnk.frame_done & ~lnk.frame_bad;
	wire [6:0] cmd_addr = lnk.rx_word[31:25];
	wire cmd_rw = lnk.rx_word[24];
	wire fault_flag_pkg::resp_kind_e cmd_kind = kind_of(lnk.rx_word);
	wire addr_bad = frame_good & (cmd_addr > `ADDR_MAX);
	wire err_evt = (lnk.frame_done & lnk.frame_bad) | addr_bad;
	wire int_req = frame_good & (cmd_kind == fault_flag_pkg::RESP_INT_REQ);
	wire soft_req = frame_good & cmd_rw &
		(cmd_kind == fault_flag_pkg::RESP_SWITCH);

	// Answer word loaded at the next chip select fall
	wire resp_fault = resp_ff == fault_flag_pkg::RESP_FAULT;
	wire resp_sw = resp_ff == fault_flag_pkg::RESP_SWITCH;
	wire [7:0] resp_head = resp_sw ? `ECHO_SW_STATUS : echo_ff;
	wire [21:0] resp_body = resp_fault ? flags_ff :
		(resp_sw ? sw_s : 22'h00_0000);
	assign lnk.tx_word = {resp_head, fault_sum_ff, intflg_ff, resp_body};

	// Clear-on-read strobes, taken when the answer word is launched
	wire fault_read = lnk.frame_start & resp_fault;
	wire int_echo = resp_ff == fault_flag_pkg::RESP_INT_REQ;
	wire event_clr = lnk.frame_start & ~int_echo;

	// Wake events; our own pulse on the line is not a wake
	wire int_fall = int_prev_ff & ~int_s;
	wire wake_fall = wake_prev_ff & ~wake_s;
	wire int_wake_evt = int_fall & sleep_s & ~pulse_on_ff;
	wire wake_evt = wake_fall;
	wire spi_wake_evt = lnk.frame_start & sleep_s;

	// Level causes hold their flag through a read; unused bits are tied
	wire [21:0] cause = {11'h000, err_evt, hash_s, 1'b0, uv_s, ov_s,
		tw_s, tl_s, int_wake_evt, wake_evt, spi_wake_evt, por_s};
	wire [21:0] keep = flags_ff & ~{22{fault_read}};
	wire [21:0] nxt_flags = (cause | keep) & `FLAG_MASK;
	wire new_flag = |(cause & ~flags_ff & `FLAG_MASK);
	wire sw_change = sw_s != sw_prev_ff;
	wire nxt_intflg = new_flag | sw_change | (intflg_ff & ~event_clr);
	wire nxt_fault_sum = (|nxt_flags) | (fault_sum_ff & ~fault_read);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flags_ff <= `FLAGS_RST;
			fault_sum_ff <= `FAULT_SUM_RST;
			intflg_ff <= `INTFLG_RST;
		end else begin
			flags_ff <= nxt_flags;
			fault_sum_ff <= nxt_fault_sum;
			intflg_ff <= nxt_intflg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			int_prev_ff <= 1'b1;
			wake_prev_ff <= 1'b1;
			sw_prev_ff <= 22'h00_0000;
		end else begin
			int_prev_ff <= int_s;
			wake_prev_ff <= wake_s;
			sw_prev_ff <= sw_s;
		end
	end

	// A malformed frame keeps its top byte as the echo
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			resp_ff <= fault_flag_pkg::RESP_ECHO;
			echo_ff <= 8'h00;
		end else if (lnk.frame_done) begin
			resp_ff <= lnk.frame_bad ? fault_flag_pkg::RESP_ECHO : cmd_kind;
			echo_ff <= lnk.rx_word[31:24];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			soft_rst_ff <= 1'b0;
		else
			soft_rst_ff <= soft_req;
	end

	// A second request during a pulse restarts the full length
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pulse_on_ff <= 1'b0;
			pulse_cnt_ff <= '0;
		end else if (int_req) begin
			pulse_on_ff <= 1'b1;
			pulse_cnt_ff <= CW'(INT_PULSE_CYCLES - 1);
		end else if (pulse_on_ff) begin
			pulse_on_ff <= pulse_cnt_ff != '0;
			pulse_cnt_ff <= pulse_cnt_ff - CW'(1);
		end
	end

	assign int_n_out = 1'b0;
	assign int_n_oe = pulse_on_ff;
	assign soft_reset_pulse = soft_rst_ff;
	assign fault_summary = fault_sum_ff;
	assign event_flag = intflg_ff;
	assign fault_flags = flags_ff;

	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	logic [CW:0] low_len_ff;
	always_ff @(posedge clk_sys) begin
		if (!rst_n || int_req)
			low_len_ff <= '0;
		else if (pulse_on_ff)
			low_len_ff <= low_len_ff + (CW+1)'(1);
	end

	sequence fault_cmd_s;
		frame_good && lnk.rx_word[31:24] == {`ADDR_FAULT, 1'b0};
	endsequence

	sequence fault_launch_s;
		lnk.frame_start && resp_fault;
	endsequence

	fault_resp_a: assert property (
		fault_cmd_s ##[1:1000] fault_launch_s |->
		lnk.tx_word[31:24] == 8'h42 && lnk.tx_word[21:0] == flags_ff)
		else $error("fault read answer wrong");

	switch_event_a: assert property (
		sw_s != $past(sw_s) |=> intflg_ff)
		else $error("switch change did not set event flag");

	frame_error_a: assert property (
		lnk.frame_done && lnk.frame_bad |=> flags_ff[10] && fault_sum_ff)
		else $error("malformed frame not latched");

	undervolt_hold_a: assert property (
		uv_s && fault_read |=> flags_ff[7])
		else $error("undervoltage flag lost while active");

	overvolt_hold_a: assert property (
		ov_s && fault_read |=> flags_ff[6])
		else $error("overvoltage flag lost while active");

	wake_pin_a: assert property (
		$fell(wake_s) |=> flags_ff[2])
		else $error("wake pin edge not latched");

	pulse_length_a: assert property (
		$fell(pulse_on_ff) |-> low_len_ff == (CW+1)'(INT_PULSE_CYCLES))
		else $error("interrupt pulse length wrong");

	pulse_start_a: assert property (
		int_req |=> int_n_oe [*8])
		else $error("interrupt pulse did not start");

	int_echo_keep_a: assert property (
		lnk.frame_start && int_echo && !new_flag && !sw_change |=>
		intflg_ff == $past(intflg_ff))
		else $error("interrupt request changed event flag");

	soft_reset_a: assert property (
		soft_req |=> soft_reset_pulse ##1 !soft_reset_pulse && resp_sw)
		else $error("soft reset pulse or answer wrong");

	unused_zero_a: assert property (
		flags_ff[21:11] == 11'h000 && !flags_ff[8])
		else $error("unused fault bit set");

	summary_hold_a: assert property (
		|flags_ff |-> fault_sum_ff)
		else $error("summary fault clear with flag set");

	read_clear_a: assert property (
		fault_read && !sleep_s |=> !flags_ff[1])
		else $error("serial wake flag not cleared by read");
endmodule

// [sim/spi_host_model.sv]
// Purpose: Host side of the serial link, master of every frame
// Assumes: Link clock idles low, host changes data on fall
// Notes: 160 ns link clock, runs only inside frames
`timescale 1ns/1ps
module spi_host_model (
	// Serial pins
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	localparam realtime HALF = 80.0;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// A count other than 32 makes a malformed frame on purpose
	task automatic frame(input logic [31:0] cmd, input int nbits,
		output logic [31:0] resp);
		resp = '0;
		cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			mosi = cmd[31 - i];
			#HALF sclk = 1'b1;
			resp = {resp[30:0], miso};
			#HALF sclk = 1'b0;
		end
		#HALF cs_n = 1'b1;
		// Released line shows the inverse, never a stale bit
		mosi = ~mosi;
		#(2 * HALF);
	endtask
endmodule

// [sim/fault_flag_command_block_tb_top.sv]
// Purpose: Self-checking bench for the fault flag command logic
// Assumes: Short interrupt pulse parameter, pull-up on the interrupt line
// Notes: Answers are checked one frame after their command
`timescale 1ns/1ps
module fault_flag_command_block_tb_top;
	localparam int PULSE = 40;
	localparam logic [31:0] FAULT_RD = 32'h4200_0000;
	localparam logic [31:0] INT_REQ = 32'h4700_0000;
	localparam logic [31:0] SOFT_RST = 32'h4900_0000;
	localparam logic [31:0] SW_RD = 32'h3e00_0000;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe, int_n_out, int_n_oe;
	logic int_ext_n, wake_n, low_sup, high_sup, warn, limit;
	logic batt_low, mismatch, sleep, soft_reset_pulse;
	logic fault_summary, event_flag;
	logic [13:0] sg;
	logic [7:0] sp;
	logic [21:0] fault_flags;
	logic [31:0] r, e;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	int hi_len = 0;
	int last_pulse = 0;
	int soft_cnt = 0;
	int oe_cnt = 0;
	integer seed = 32'h990f;
	// Open drain line: either party may pull it low
	wire int_line = (int_n_oe ? int_n_out : 1'b1) & int_ext_n;

	fault_flag_command_block #(.INT_PULSE_CYCLES(PULSE)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.int_n_in(int_line), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
		.wake_n(wake_n), .ground_switch_inputs(sg),
		.programmable_switch_inputs(sp), .low_supply_cmp(low_sup),
		.high_supply_cmp(high_sup), .thermal_warning_cmp(warn),
		.thermal_limit_cmp(limit), .battery_supply_low(batt_low),
		.hash_mismatch(mismatch), .sleep_state(sleep),
		.soft_reset_pulse(soft_reset_pulse),
		.fault_summary(fault_summary), .event_flag(event_flag),
		.fault_flags(fault_flags));

	spi_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso));

	always #2.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles++;
		if (int_n_oe === 1'b1)
			hi_len++;
		else begin
			if (hi_len != 0)
				last_pulse = hi_len;
			hi_len = 0;
		end
		if (soft_reset_pulse === 1'b1)
			soft_cnt++;
		if (miso_oe === 1'b1)
			oe_cnt++;
		if (cycles == 60000) begin
			failures++;
			conclude();
		end
	end

	function automatic logic [31:0] answer(input logic [7:0] head,
		input logic sum, input logic evt, input logic [21:0] body);
		return {head, sum, evt, body};
	endfunction

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Frame, then let the decode land before anything is looked at
	task automatic xfer(input logic [31:0] cmd, input int n = 32);
		host.frame(cmd, n, r);
		repeat (4) @(negedge clk_sys);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		{int_ext_n, wake_n} = 2'b11;
		{low_sup, high_sup, warn, limit, batt_low, mismatch} = 6'h00;
		sleep = 1'b0;
		sg = '0;
		sp = '0;
		repeat (3) @(negedge clk_sys);
		check("summary", fault_summary, 1);
		check("event", event_flag, 1);
		check("flags", fault_flags, 32'h1);
		check("idle outs", {miso_oe, int_n_oe, soft_reset_pulse},
			0);
		check("pull only", int_n_out, 0);
		rst_n = 1'b1;
		repeat (8) @(negedge clk_sys);
		xfer(FAULT_RD);
		check("reset answer", r, answer(8'h00, 1, 1, 22'h0));
		xfer(INT_REQ);
		check("fault answer", r, answer(8'h42, 1, 0, 22'h1));
		check("por cleared", fault_flags, 0);
		check("summary cleared", fault_summary, 0);
		check("event cleared", event_flag, 0);
		repeat (PULSE + 20) @(negedge clk_sys);
		check("pulse length", last_pulse, PULSE);
		sg = sg ^ (14'h1 << ($unsigned($random(seed)) % 14));
		repeat (10) @(negedge clk_sys);
		check("switch event", event_flag, 1);
		xfer(FAULT_RD);
		check("request echo", r, answer(8'h47, 0, 1, 22'h0));
		check("event kept", event_flag, 1);
		{low_sup, high_sup, warn, limit, batt_low, mismatch} = 6'h3f;
		repeat (10) @(negedge clk_sys);
		check("summary set", fault_summary, 1);
		xfer(FAULT_RD);
		check("causes", r,
			answer(8'h42, 1, 1, 22'h2f1));
		check("re-set", fault_flags, 32'h2f1);
		{low_sup, high_sup, warn, limit, batt_low, mismatch} = 6'h00;
		repeat (10) @(negedge clk_sys);
		oe_cnt = 0;
		xfer(SOFT_RST);
		// Output enable follows the host's select low time, 65 half bits
		check("drive time", oe_cnt, (2 * 32 + 1) * 16);
		e = answer(8'h42, 1, 0, 22'h2f1);
		check("latched", {r[31:23], r[21:0]},
			{e[31:23], e[21:0]});
		check("gone and read", fault_flags, 0);
		check("summary off", fault_summary, 0);
		check("soft pulses", soft_cnt, 1);
		for (int i = 0; i < 4; i++) begin
			sg = $random(seed);
			sp = $random(seed);
			repeat (10) @(negedge clk_sys);
			xfer(SW_RD);
			e = answer(8'h3e, 0, 0, {sp, sg});
			check("switch word", {r[31:23], r[21:0]},
				{e[31:23], e[21:0]});
			check("event read", event_flag, 0);
		end
		xfer(32'hfe00_0000);
		check("bad address", fault_flags, 32'h400);
		xfer(FAULT_RD);
		check("bad echo", r, answer(8'hfe, 1, 1, 22'h0));
		xfer(SW_RD);
		check("error read", r[21:0], 22'h400);
		check("error clear", fault_flags, 0);
		xfer(SW_RD, 31);
		check("bad length", fault_flags, 32'h400);
		sleep = 1'b1;
		wake_n = 1'b0;
		repeat (10) @(negedge clk_sys);
		wake_n = 1'b1;
		int_ext_n = 1'b0;
		repeat (10) @(negedge clk_sys);
		int_ext_n = 1'b1;
		repeat (10) @(negedge clk_sys);
		xfer(SW_RD);
		sleep = 1'b0;
		check("wakes", fault_flags, 32'h40e);
		xfer(FAULT_RD);
		xfer(INT_REQ);
		check("wake read", r[21:0], 22'h40e);
		check("wake clear", fault_flags, 0);
		repeat (PULSE + 20) @(negedge clk_sys);
		check("pulse again", last_pulse, PULSE);
		// Nonzero data makes both write commands plain echoes
		xfer(INT_REQ | 32'h0000_0001);
		check("no pulse", int_n_oe, 0);
		xfer(SOFT_RST | 32'h0000_0001);
		check("refused echo", r, answer(8'h47, 0, 0, 22'h0));
		check("no soft reset", soft_cnt, 1);
		xfer(SW_RD);
		check("soft echo", r, answer(8'h49, 0, 0, 22'h0));
		conclude();
	end
endmodule
